//--- shared/usart_regs.svh
`ifndef USART_REGS_SVH
`define USART_REGS_SVH

// ********************************************************************
// Register indices; the APB byte address is four times the index.
// ********************************************************************
`define IDX_PERIPH_FLAG     10'h00C
`define IDX_RECV_CTRL       10'h018
`define IDX_HOLD_BUF        10'h019
`define IDX_PERIPH_ENABLE   10'h08C
`define IDX_XMIT_CTRL       10'h098
`define IDX_BAUD_DIV        10'h099

// ********************************************************************
// Field positions.
// ********************************************************************
`define XMIT_CLK_SRC_BIT    7
`define XMIT_NINTH_EN_BIT   6
`define XMIT_ENABLE_BIT     5
`define XMIT_SYNC_BIT       4
`define XMIT_HIGH_SPEED_BIT 2
`define XMIT_SHIFT_EMPTY_BIT 1
`define XMIT_NINTH_VAL_BIT  0
`define RECV_PORT_EN_BIT    7
`define RECV_NINTH_EN_BIT   6
`define RECV_SINGLE_BIT     5
`define RECV_CONT_BIT       4
`define PERIPH_TX_BIT       4

// ********************************************************************
// Reset values.
// ********************************************************************
`define XMIT_CTRL_RESET     8'h02
`define RECV_CTRL_RESET     8'h00
`define BAUD_DIV_RESET      8'h00

// ********************************************************************
// Rate timer ticks per bit, less one; bits per frame.
// ********************************************************************
`define TICKS_ASYNC_LOW     6'h3F
`define TICKS_ASYNC_HIGH    6'h0F
`define TICKS_SYNC          6'h03
`define FRAME_BITS_8        4'hA
`define FRAME_BITS_9        4'hB

`endif

//--- shared/usart_pkg.sv
package usart_pkg;

   typedef enum logic [2:0]
   {
      TX_IDLE  = 3'b001,
      TX_ARMED = 3'b010,
      TX_SHIFT = 3'b100
   } tx_state_t;

   typedef logic [7:0] byte_t;

endpackage

//--- core/rate_timer.sv
`timescale 1ns/1ps

// Free-running up counter; one tick per (divisor + 1) enabled cycles.
module rate_timer #(
   parameter int WIDTH = 8
) (
   input  wire logic             clock,
   input  wire logic             srst,
   input  wire logic             run,
   input  wire logic             restart,
   input  wire logic [WIDTH-1:0] divisor,
   output logic                  tick
);

   logic [WIDTH-1:0] count_q;

   always_ff @(posedge clock)
   begin
      if (srst || restart)
      begin
         count_q <= '0;
         tick    <= 1'b0;
      end
      else if (run)
      begin
         if (count_q >= divisor)
         begin
            count_q <= '0;
            tick    <= 1'b1;
         end
         else
         begin
            count_q <= count_q + 1'b1;
            tick    <= 1'b0;
         end
      end
      // The tick is held while stopped, so a frozen cycle resumes exactly where it stopped.
   end

endmodule

//--- core/majority_sampler.sv
`timescale 1ns/1ps

// Three samples near mid-bit; two of three decide the level.
module majority_sampler (
   input  wire logic clock,
   input  wire logic srst,
   input  wire logic clkEn,
   input  wire logic sampleEn,
   input  wire logic decide,
   input  wire logic lineIn,
   output logic      level
);

   logic [2:0] samples_q;

   always_ff @(posedge clock)
   begin
      if (srst)
      begin
         samples_q <= 3'h7;
         level     <= 1'b1;
      end
      else if (clkEn)
      begin
         if (sampleEn)
         begin
            samples_q <= {samples_q[1:0], lineIn};
         end
         if (decide)
         begin
            level <= (samples_q[0] & samples_q[1]) | (samples_q[0] & samples_q[2])
                     | (samples_q[1] & samples_q[2]);
         end
      end
   end

endmodule

//--- core/usart_baud_gen_async_tx.sv
`timescale 1ns/1ps
`include "usart_regs.svh"

// What this block does
// - Rate timer is a free-running 8-bit counter with period set by divisor.
// - High-speed select matters only in asynchronous mode.
// - Bit rate is clock over 64, 16 or 4 times (divisor plus one).
// - Writing the divisor restarts the rate timer at once.
// - Receive line level per bit is a majority of three mid-bit samples.
// - Frame is NRZ: start bit, eight or nine data bits, stop bit.
// - Data bits go least significant bit first.
// - Asynchronous bit clock is 16 or 64 rate ticks, by high-speed select.
// - Asynchronous operation halts during sleep.
// - Asynchronous mode whenever the sync mode bit is clear.
// - Shift register reloads only after the stop bit has gone out.
// - Buffer to shift register move takes one cycle and sets the empty flag.
// - Empty flag is not software clearable; a buffer write clears it.
// - Interrupt request only while the transmit interrupt enable is set.
// - Read-only shift-empty bit shows shift register empty; no interrupt.
// - Setting transmit enable sets the buffer-empty flag.
// - Output starts once buffer holds data and a shift clock arrives.
// - Buffer write with idle shift register moves straight through.
// - Clearing transmit enable aborts the frame and releases the pin.
// - Shift register has no address.
// - Transmit and receive sides share one bit rate; the receive side has no framing.
module usart_baud_gen_async_tx (
   input  wire logic        clock,
   input  wire logic        srst,
   input  wire logic        clkEn,
   input  wire logic        sleepReq,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   input  wire logic        rxIn,
   output logic             rxLevel,
   output logic             txOut,
   output logic             txOeN,
   output logic             txIrq
);

   import usart_pkg::*;

   // ********************************************************************
   // Registers and state.
   // ********************************************************************
   logic [7:0]   xmitCtrl_q;
   logic [7:0]   recvCtrl_q;
   logic [7:0]   baudDiv_q;
   usart_pkg::byte_t holdBuf_q;
   logic         holdFull_q;
   logic         emptyFlag_q;
   logic         txIntEn_q;
   tx_state_t    txState_q;
   logic [10:0]  shifter_q;
   logic [3:0]   bitsLeft_q;
   logic [5:0]   phase_q;
   logic         accessOk_q;

   logic         apbSetup;
   logic         apbDone;
   logic         wrBaud;
   logic         wrXmit;
   logic         wrRecv;
   logic         wrHold;
   logic         wrEnable;
   logic         mapped;
   logic [9:0]   regIdx;
   logic [31:0]  readMux;

   logic         syncMode;
   logic         txEnable;
   logic         runTimer;
   logic         rateTick;
   logic [5:0]   lastPhase;
   logic [5:0]   midPhase;
   logic         bitTick;
   logic         frameEnd;
   logic         loadNow;
   logic [10:0]  newFrame;
   logic [3:0]   newBits;

   // ********************************************************************
   // APB slave: no wait states, so the answer comes in the first access cycle.
   // ********************************************************************
   assign regIdx   = paddr[11:2];
   assign apbSetup = psel && !penable;
   assign apbDone  = clkEn && psel && penable && pready;
   assign wrBaud   = apbDone && pwrite && accessOk_q && (regIdx == `IDX_BAUD_DIV);
   assign wrXmit   = apbDone && pwrite && accessOk_q && (regIdx == `IDX_XMIT_CTRL);
   assign wrRecv   = apbDone && pwrite && accessOk_q && (regIdx == `IDX_RECV_CTRL);
   assign wrHold   = apbDone && pwrite && accessOk_q && (regIdx == `IDX_HOLD_BUF);
   assign wrEnable = apbDone && pwrite && accessOk_q && (regIdx == `IDX_PERIPH_ENABLE);

   always_comb
   begin
      mapped  = (paddr[1:0] == 2'h0);
      readMux = 32'h0000_0000;
      unique case (regIdx)
         `IDX_BAUD_DIV:      readMux[7:0] = baudDiv_q;
         `IDX_XMIT_CTRL:     readMux[7:0] = {xmitCtrl_q[7:4], 1'b0, xmitCtrl_q[2],
                                              txState_q == TX_IDLE, xmitCtrl_q[0]};
         `IDX_RECV_CTRL:     readMux[7:0] = {recvCtrl_q[7:4], 4'h0};
         `IDX_HOLD_BUF:      readMux[7:0] = holdBuf_q;
         `IDX_PERIPH_FLAG:   readMux[`PERIPH_TX_BIT] = emptyFlag_q;
         `IDX_PERIPH_ENABLE: readMux[`PERIPH_TX_BIT] = txIntEn_q;
         default:            mapped = 1'b0;
      endcase
   end

   always_ff @(posedge clock)
   begin
      if (srst)
      begin
         pready     <= 1'b0;
         pslverr    <= 1'b0;
         prdata     <= 32'h0000_0000;
         accessOk_q <= 1'b0;
      end
      else if (clkEn)
      begin
         pready     <= apbSetup;
         pslverr    <= apbSetup && !mapped;
         accessOk_q <= apbSetup && mapped;
         if (apbSetup && !pwrite)
         begin
            prdata <= mapped ? readMux : 32'h0000_0000;
         end
      end
   end

   // ********************************************************************
   // Control registers. The shift register itself is never decoded.
   // ********************************************************************
   always_ff @(posedge clock)
   begin
      if (srst)
      begin
         xmitCtrl_q <= `XMIT_CTRL_RESET;
         recvCtrl_q <= `RECV_CTRL_RESET;
         baudDiv_q  <= `BAUD_DIV_RESET;
         txIntEn_q  <= 1'b0;
      end
      else if (clkEn)
      begin
         if (wrXmit)
         begin
            xmitCtrl_q <= pwdata[7:0] & 8'hF5;
         end
         if (wrRecv)
         begin
            recvCtrl_q <= pwdata[7:0] & 8'hF0;
         end
         if (wrBaud)
         begin
            baudDiv_q <= pwdata[7:0];
         end
         if (wrEnable)
         begin
            txIntEn_q <= pwdata[`PERIPH_TX_BIT];
         end
      end
   end

   // ********************************************************************
   // Rate generation shared by both directions.
   // ********************************************************************
   assign syncMode = xmitCtrl_q[`XMIT_SYNC_BIT];
   assign txEnable = xmitCtrl_q[`XMIT_ENABLE_BIT] && !syncMode
                     && recvCtrl_q[`RECV_PORT_EN_BIT];
   assign runTimer = clkEn && !(sleepReq && !syncMode);

   rate_timer #(
      .WIDTH (8)
   ) u_rate_timer (
      .clock   (clock),
      .srst    (srst),
      .run     (runTimer),
      .restart (wrBaud),
      .divisor (baudDiv_q),
      .tick    (rateTick)
   );

   // High-speed select is consulted only when the sync bit is clear.
   always_comb
   begin
      if (syncMode)
      begin
         lastPhase = `TICKS_SYNC;
      end
      else if (xmitCtrl_q[`XMIT_HIGH_SPEED_BIT])
      begin
         lastPhase = `TICKS_ASYNC_HIGH;
      end
      else
      begin
         lastPhase = `TICKS_ASYNC_LOW;
      end
      midPhase = {1'b0, lastPhase[5:1]};
   end

   always_ff @(posedge clock)
   begin
      if (srst || wrBaud)
      begin
         phase_q <= 6'h00;
      end
      else if (runTimer && rateTick)
      begin
         phase_q <= (phase_q >= lastPhase) ? 6'h00 : phase_q + 6'h01;
      end
   end

   assign bitTick = runTimer && rateTick && (phase_q >= lastPhase);

   majority_sampler u_majority_sampler (
      .clock    (clock),
      .srst     (srst),
      .clkEn    (runTimer),
      .sampleEn (rateTick && (phase_q + 6'h01 >= midPhase) && (phase_q <= midPhase + 6'h01)),
      .decide   (rateTick && (phase_q == midPhase + 6'h02)),
      .lineIn   (rxIn),
      .level    (rxLevel)
   );

   // ********************************************************************
   // Frame building.
   // ********************************************************************
   // A stop bit stands above the ninth bit; in 8-bit frames the ninth
   // position is shifted out as the stop bit, so it is filled with a one.
   assign newFrame = {1'b1,
                      xmitCtrl_q[`XMIT_NINTH_EN_BIT] ? xmitCtrl_q[`XMIT_NINTH_VAL_BIT] : 1'b1,
                      holdBuf_q, 1'b0};
   assign newBits  = xmitCtrl_q[`XMIT_NINTH_EN_BIT] ? `FRAME_BITS_9 : `FRAME_BITS_8;

   assign frameEnd = (txState_q == TX_SHIFT) && bitTick && (bitsLeft_q == 4'h1);
   // A write in this very cycle defers the move by one cycle so the word
   // taken is always the newest one.
   assign loadNow  = txEnable && holdFull_q && !wrHold
                     && ((txState_q == TX_IDLE) || frameEnd);

   // ********************************************************************
   // Holding buffer and its empty flag.
   // ********************************************************************
   always_ff @(posedge clock)
   begin
      if (srst)
      begin
         holdBuf_q  <= 8'h00;
         holdFull_q <= 1'b0;
      end
      else if (clkEn)
      begin
         if (wrHold)
         begin
            holdBuf_q  <= pwdata[7:0];
            holdFull_q <= 1'b1;
         end
         else if (loadNow)
         begin
            holdFull_q <= 1'b0;
         end
      end
   end

   always_ff @(posedge clock)
   begin
      if (srst)
      begin
         emptyFlag_q <= 1'b0;
      end
      else if (clkEn)
      begin
         if (loadNow)
         begin
            emptyFlag_q <= 1'b1;
         end
         else if (wrXmit && pwdata[`XMIT_ENABLE_BIT] && !xmitCtrl_q[`XMIT_ENABLE_BIT])
         begin
            emptyFlag_q <= 1'b1;
         end
         else if (wrHold)
         begin
            emptyFlag_q <= 1'b0;
         end
      end
   end

   always_ff @(posedge clock)
   begin
      if (srst)
      begin
         txIrq <= 1'b0;
      end
      else if (clkEn)
      begin
         txIrq <= emptyFlag_q && txIntEn_q;
      end
   end

   // ********************************************************************
   // Transmit shifter.
   // ********************************************************************
   always_ff @(posedge clock)
   begin
      if (srst)
      begin
         txState_q  <= TX_IDLE;
         shifter_q  <= 11'h7FF;
         bitsLeft_q <= 4'h0;
         txOut      <= 1'b1;
      end
      else if (clkEn)
      begin
         if (!txEnable)
         begin
            txState_q  <= TX_IDLE;
            bitsLeft_q <= 4'h0;
            txOut      <= 1'b1;
         end
         else
         begin
            unique case (txState_q)
               TX_IDLE:
               begin
                  txOut <= 1'b1;
                  if (loadNow)
                  begin
                     txState_q  <= TX_ARMED;
                     shifter_q  <= newFrame;
                     bitsLeft_q <= newBits;
                  end
               end
               TX_ARMED:
               begin
                  if (bitTick)
                  begin
                     txState_q <= TX_SHIFT;
                     txOut     <= shifter_q[0];
                  end
               end
               TX_SHIFT:
               begin
                  if (loadNow)
                  begin
                     shifter_q  <= newFrame;
                     bitsLeft_q <= newBits;
                     txOut      <= newFrame[0];
                  end
                  else if (frameEnd)
                  begin
                     txState_q <= TX_IDLE;
                     txOut     <= 1'b1;
                  end
                  else if (bitTick)
                  begin
                     shifter_q  <= {1'b1, shifter_q[10:1]};
                     bitsLeft_q <= bitsLeft_q - 4'h1;
                     txOut      <= shifter_q[1];
                  end
               end
            endcase
         end
      end
   end

   // The pin floats whenever the transmitter is not enabled.
   always_ff @(posedge clock)
   begin
      if (srst)
      begin
         txOeN <= 1'b1;
      end
      else if (clkEn)
      begin
         txOeN <= !txEnable;
      end
   end

endmodule

//--- verification/usart_tx_chk.sv
`timescale 1ns/1ps

module usart_tx_chk (
   input wire logic        clock,
   input wire logic        srst,
   input wire logic        clkEn,
   input wire logic        sleepReq,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic        pready,
   input wire logic        pslverr,
   input wire logic        rxIn,
   input wire logic        rxLevel,
   input wire logic        txOut,
   input wire logic        txOeN,
   input wire logic        txIrq
);
   default clocking cb @(posedge clock); endclocking
   default disable iff (srst);

   // A steady line for longer than the slowest bit used must have been voted in.
   logic       rxPrev_q;
   logic [8:0] rxCnt_q;

   always_ff @(posedge clock)
   begin
      rxPrev_q <= rxIn;
      if (srst || rxIn != rxPrev_q)
         rxCnt_q <= 9'h000;
      else if (rxCnt_q < 9'h190)
         rxCnt_q <= rxCnt_q + 9'h001;
   end

   apb_ready_a: assert property (psel && !penable && clkEn |=> pready) else $error("no ready after setup");
   ready_pulse_a: assert property (pready |=> !pready) else $error("ready longer than one cycle");
   bad_addr_a: assert property (psel && !penable && paddr[1:0] != 2'b00 |=> pslverr) else $error("misaligned not refused");
   err_zero_a: assert property (pready && pslverr && !pwrite |-> prdata == 32'h0) else $error("refused read not zero");
   idle_high_a: assert property (txOeN |-> txOut) else $error("released pin not high");
   start_hold_a: assert property ($fell(txOut) |=> (!txOut || txOeN) [*8])
      else $error("low bit shorter than minimum");
   oe_by_write_a: assert property ($changed(txOeN) |-> $past(pready && pwrite, 1) || $past(pready && pwrite, 2))
      else $error("pin enable moved without a write");
   rx_vote_a: assert property (rxCnt_q == 9'h12C |-> rxLevel == rxIn) else $error("steady line not voted");

   cover property (pready && pslverr);
   cover property ($fell(txOut));
   cover property ($rose(txOeN));
   cover property (rxCnt_q == 9'h12C && !rxIn);
endmodule

bind usart_baud_gen_async_tx usart_tx_chk chk (.clock, .srst, .clkEn, .sleepReq, .psel, .penable, .pwrite, .paddr,
   .pwdata, .prdata, .pready, .pslverr, .rxIn, .rxLevel, .txOut, .txOeN, .txIrq);

//--- verification/serial_peer.sv
`timescale 1ns/1ps

// Remote end of the line; a released pin is pulled high.
module serial_peer (
   input  wire logic clock,
   input  wire logic txLine,
   input  wire logic txOeN,
   input  var  int   bitClocks,
   input  wire logic nineBits,
   output logic      rxLine
);
   logic [8:0] frames[$];
   logic [8:0] word;
   wire logic  line = txOeN ? 1'b1 : txLine;

   initial rxLine = 1'b1;

   task lineTo(input logic v);
      rxLine <= v;
   endtask

   // Samples at mid-bit, so a wrong bit rate corrupts the captured word.
   initial forever
   begin
      @(negedge line);
      repeat (bitClocks / 2) @(posedge clock);
      if (line === 1'b0)
      begin
         word = 9'h000;
         for (int i = 0; i < 9; i++)
            if (i < 8 || nineBits)
            begin
               repeat (bitClocks) @(posedge clock);
               word[i] = line;
            end
         repeat (bitClocks) @(posedge clock);
         if (line === 1'b1)
            frames.push_back(word);
      end
   end
endmodule

//--- verification/usart_baud_gen_async_tx_bench.sv
`timescale 1ns/1ps
`include "usart_regs.svh"

module usart_baud_gen_async_tx_bench;
   import usart_pkg::*;
   localparam logic [11:0] FLAGS = {`IDX_PERIPH_FLAG, 2'b00};
   localparam logic [11:0] RECV  = {`IDX_RECV_CTRL, 2'b00};
   localparam logic [11:0] HOLD  = {`IDX_HOLD_BUF, 2'b00};
   localparam logic [11:0] IEN   = {`IDX_PERIPH_ENABLE, 2'b00};
   localparam logic [11:0] XCTL  = {`IDX_XMIT_CTRL, 2'b00};
   localparam logic [11:0] DIV   = {`IDX_BAUD_DIV, 2'b00};
   logic        clock, srst, clkEn, sleepReq, psel, penable, pwrite, nineBits;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic        pready, pslverr, rxIn, rxLevel, txOut, txOeN, txIrq, err;
   int          failCount, checked, cycles, bitClocks;

   usart_baud_gen_async_tx dut (.clock, .srst, .clkEn, .sleepReq, .psel, .penable, .pwrite, .paddr, .pwdata,
      .prdata, .pready, .pslverr, .rxIn, .rxLevel, .txOut, .txOeN, .txIrq);
   serial_peer peer (.clock, .txLine(txOut), .txOeN, .bitClocks, .nineBits, .rxLine(rxIn));

   initial
   begin
      clock = 1'b0;
      forever #5 clock = ~clock;
   end

   task test_done;
      $display("Comparisons %0d, mismatches %0d", checked, failCount);
      if (failCount == 0 && checked > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask

   always @(posedge clock)
   begin
      cycles++;
      if (cycles == 50000)
      begin
         failCount++;
         test_done;
      end
   end

   task chk(input logic [31:0] got, input logic [31:0] exp);
      checked++;
      if (got !== exp)
      begin
         $display("Error at %0t: got %h expected %h", $time, got, exp);
         failCount++;
      end
   endtask

   // One transfer, then one idle edge so no signal is assigned twice at one edge.
   task apb(input logic [11:0] a, input logic w, input logic [31:0] d);
      psel <= 1'b1;
      penable <= 1'b0;
      paddr <= a;
      pwrite <= w;
      pwdata <= d;
      @(posedge clock);
      penable <= 1'b1;
      do
      begin
         @(posedge clock);
      end
      while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge clock);
   endtask

   task rdChk(input logic [11:0] a, input logic [31:0] exp);
      apb(a, 1'b0, 32'h0);
      chk(rd, exp);
   endtask

   task startLen(input int exp);
      int n;
      n = 0;
      while (txOut !== 1'b0 && n < 3000)
      begin
         @(posedge clock);
         n++;
      end
      n = 0;
      while (txOut === 1'b0 && n < 3000)
      begin
         @(posedge clock);
         n++;
      end
      chk(n, exp);
   endtask

   task waitFrames(input int k);
      int n;
      n = 0;
      while (peer.frames.size() < k && n < 8000)
      begin
         @(posedge clock);
         n++;
      end
      chk(peer.frames.size(), k);
      repeat (bitClocks) @(posedge clock);
   endtask

   task t_regs;
      rdChk(XCTL, 32'h02);
      rdChk(RECV, 32'h00);
      rdChk(DIV, 32'h00);
      rdChk(FLAGS, 32'h00);
      apb(12'h100, 1'b0, 32'h0);
      chk(err, 1'b1);
      apb(12'h261, 1'b1, 32'hFF);
      chk(err, 1'b1);
      rdChk(XCTL, 32'h02);
   endtask

   task t_frame;
      bitClocks = 32;
      apb(DIV, 1'b1, 32'h01);
      apb(RECV, 1'b1, 32'h80);
      apb(XCTL, 1'b1, 32'h24);
      rdChk(XCTL, 32'h26);
      rdChk(FLAGS, 32'h10);
      apb(HOLD, 1'b1, 32'hA5);
      startLen(32);
      rdChk(XCTL, 32'h24);
      waitFrames(1);
      chk(peer.frames.pop_front(), 32'h0A5);
   endtask

   task t_b2b;
      apb(IEN, 1'b1, 32'h10);
      apb(HOLD, 1'b1, 32'h3C);
      apb(HOLD, 1'b1, 32'hC3);
      rdChk(FLAGS, 32'h00);
      chk(txIrq, 1'b0);
      waitFrames(2);
      chk(peer.frames.pop_front(), 32'h03C);
      chk(peer.frames.pop_front(), 32'h0C3);
      chk(txIrq, 1'b1);
      apb(FLAGS, 1'b1, 32'h0);
      rdChk(FLAGS, 32'h10);
      apb(IEN, 1'b1, 32'h0);
      repeat (2) @(posedge clock);
      chk(txIrq, 1'b0);
      rdChk(XCTL, 32'h26);
   endtask

   task t_ninth;
      nineBits = 1'b1;
      apb(XCTL, 1'b1, 32'h65);
      apb(HOLD, 1'b1, 32'h3C);
      waitFrames(1);
      chk(peer.frames.pop_front(), 32'h13C);
      nineBits = 1'b0;
   endtask

   task t_abort;
      apb(XCTL, 1'b1, 32'h24);
      apb(HOLD, 1'b1, 32'h00);
      repeat (3 * bitClocks) @(posedge clock);
      apb(XCTL, 1'b1, 32'h04);
      repeat (2) @(posedge clock);
      chk(txOeN, 1'b1);
      chk(txOut, 1'b1);
      rdChk(XCTL, 32'h06);
      repeat (12 * bitClocks) @(posedge clock);
      peer.frames.delete();
      apb(HOLD, 1'b1, 32'h5A);
      apb(XCTL, 1'b1, 32'h24);
      waitFrames(1);
      chk(peer.frames.pop_front(), 32'h05A);
   endtask

   task t_slow;
      apb(DIV, 1'b1, 32'h00);
      apb(XCTL, 1'b1, 32'h20);
      bitClocks = 64;
      apb(HOLD, 1'b1, 32'h55);
      startLen(64);
      waitFrames(1);
      chk(peer.frames.pop_front(), 32'h055);
   endtask

   task t_sleep;
      sleepReq <= 1'b1;
      apb(HOLD, 1'b1, 32'h96);
      repeat (4 * bitClocks) @(posedge clock);
      chk(txOut, 1'b1);
      rdChk(XCTL, 32'h20);
      sleepReq <= 1'b0;
      waitFrames(1);
      chk(peer.frames.pop_front(), 32'h096);
   endtask

   // A start bit frozen by the clock enable must stretch by exactly the frozen cycles.
   task t_freeze;
      int n;
      n = 0;
      apb(HOLD, 1'b1, 32'h0F);
      while (txOut !== 1'b0)
         @(posedge clock);
      clkEn <= 1'b0;
      repeat (200)
      begin
         @(posedge clock);
         if (txOut === 1'b0)
            n++;
      end
      clkEn <= 1'b1;
      while (txOut === 1'b0)
      begin
         @(posedge clock);
         n++;
      end
      chk(n, 264);
      repeat (24 * bitClocks) @(posedge clock);
      peer.frames.delete();
   endtask

   task t_rx;
      int bad;
      bad = 0;
      peer.lineTo(1'b0);
      repeat (320) @(posedge clock);
      chk(rxLevel, 1'b0);
      peer.lineTo(1'b1);
      @(posedge clock);
      peer.lineTo(1'b0);
      repeat (200)
      begin
         @(posedge clock);
         if (rxLevel !== 1'b0)
            bad++;
      end
      chk(bad, 0);
      peer.lineTo(1'b1);
      repeat (300) @(posedge clock);
      chk(rxLevel, 1'b1);
   endtask

   initial
   begin
      srst = 1'b1;
      clkEn = 1'b1;
      sleepReq = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 12'h000;
      pwdata = 32'h0;
      failCount = 0;
      checked = 0;
      cycles = 0;
      bitClocks = 32;
      nineBits = 1'b0;
      repeat (6) @(posedge clock);
      srst <= 1'b0;
      t_regs;
      t_frame;
      t_b2b;
      t_ninth;
      t_abort;
      t_slow;
      t_sleep;
      t_freeze;
      t_rx;
      test_done;
   end
endmodule
